// [telegram_params.svh]
// constants for the fieldbus telegram status framer
`ifndef TELEGRAM_PARAMS_SVH
`define TELEGRAM_PARAMS_SVH
// status byte zero bit positions
`define STS_WACK_BIT 0
`define STS_SERVICE_BIT 2
`define STS_PEND_BIT 3
`define STS_BLOCK_BIT 4
`define STS_LOSS_BIT 5
`define STS_OVERFLOW_BIT 6
`define STS_NEWDATA_BIT 7
// control byte one command bit positions
`define CMD_FLUSH_BIT 2
`define CMD_APPEND_BIT 3
// telegram byte indices
`define TG_CTRL0_IDX 8'h00
`define TG_CTRL1_IDX 8'h01
`define TG_DATA_IDX 8'h02
// serial framing characters
`define SER_START_CHAR 8'h02
`define SER_CR_CHAR 8'h0D
`define SER_LF_CHAR 8'h0A
// reset values
`define STS_RESET 8'h00
`define LEN_RESET 8'h00
// buffer sizes
`define TX_BUF_BYTES 1024
`define FIFO_DEPTH 16
`define FIFO_WIDTH 8
`endif

// [telegram_pkg.sv]
// types shared by the telegram framer files
`default_nettype none
package telegram_pkg;
    // serial output framing states
    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_CR_LF} ser_state_t;
    // service selector positions
    typedef enum logic [1:0] {SVC_RUN, SVC_GATEWAY, SVC_PERIPH} svc_sel_t;
endpackage : telegram_pkg
`default_nettype wire

// [byte_fifo.sv]
// parameterised valid/ready fifo held in flip-flops
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_clear, // synchronous flush
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage entries
    logic [AW-1:0] wr_q; // write index
    logic [AW-1:0] rd_q; // read index
    logic [AW:0] cnt_q; // fill count
    logic push;
    logic pop;

    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_q];

    // entry writes, one generate slot per entry
    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
            if (!i_arst_n) begin
                mem_q[g] <= '0;
            end else if (push && wr_q == AW'(g)) begin
                mem_q[g] <= i_in_data;
            end
        end
    end

    // pointers and count
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_clear) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : byte_fifo
`default_nettype wire

// [telegram_status_framer.sv]
// fieldbus telegram framer: status bytes, payload forwarding, serial frame
`include "telegram_params.svh"
`default_nettype none
module telegram_status_framer
    import telegram_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // controller -> gateway telegram byte stream
    input wire logic i_out_valid, // byte strobe
    input wire logic [7:0] i_out_byte, // telegram byte
    input wire logic i_out_first, // marks control byte zero
    input wire logic i_out_last, // marks last telegram byte
    // gateway -> controller telegram byte stream
    input wire logic i_in_rd, // controller fetches next input byte
    input wire logic [7:0] i_in_index, // byte position being fetched
    output logic [7:0] o_in_byte, // registered input byte
    // end device received data set
    input wire logic i_rx_valid, // received payload byte
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end, // end of received data set
    input wire logic i_rx_lost, // a received set could not be delivered
    // configuration and environment
    input wire logic [7:0] i_data_len_cfg, // configured telegram data length
    input wire logic i_transparent, // 1 transparent, 0 collective
    input wire logic [1:0] i_svc_sel, // service selector position
    input wire logic i_reset_cmd, // reset command from controller
    input wire logic [10:0] i_tx_buf_level, // collective transmit buffer fill
    input wire logic [10:0] i_buf_level, // gateway buffer fill, bytes
    // serial end device side
    output logic o_ser_valid,
    output logic [7:0] o_ser_byte,
    input wire logic i_ser_ready,
    output logic o_rts, // serial request-to-send
    // status bytes visible to the controller
    output logic [7:0] o_status_flags_byte,
    output logic [7:0] o_payload_length_byte
);
    // status flag registers
    logic write_ack_q; // write acknowledge toggle
    logic service_mode_flag_q;
    logic pending_data_flag_q;
    logic block_ready_toggle_q;
    logic data_loss_flag_q;
    logic buffer_overflow_flag_q;
    logic new_data_toggle_q;
    logic [7:0] payload_length_code_q; // length of loaded input payload
    logic [7:0] cmd_select_q; // latched control byte one
    logic [7:0] out_pos_q; // position within the output telegram
    logic [7:0] in_data_q [256]; // input data bytes to the controller
    logic [7:0] rx_cnt_q; // bytes of current received set
    logic rx_trunc_q; // current received set overflowed
    logic [7:0] in_byte_q;
    // fifo between payload stripper and serial framer
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic payload_byte;
    logic cmd_done;
    logic cmd_append;
    logic cmd_flush;
    logic drop_byte;
    ser_state_t ser_q;
    logic lf_q; // second terminator pending
    logic [7:0] ser_byte_q;
    logic ser_have_data_q; // payload seen since start char

    // payload begins at the third byte; first two are consumed here
    assign payload_byte = i_out_valid && !i_out_first && out_pos_q >= `TG_DATA_IDX;
    // bytes beyond the configured length are dropped
    assign drop_byte = payload_byte && (out_pos_q - `TG_DATA_IDX) >= i_data_len_cfg;
    assign fifo_in_valid = payload_byte && !drop_byte;
    assign cmd_append = cmd_select_q[`CMD_APPEND_BIT];
    assign cmd_flush = cmd_select_q[`CMD_FLUSH_BIT];
    // a command completes when its telegram ends
    assign cmd_done = i_out_valid && i_out_last && (cmd_append || cmd_flush ||
        (i_out_first ? 1'b0 : (out_pos_q == `TG_CTRL1_IDX &&
        (i_out_byte[`CMD_APPEND_BIT] || i_out_byte[`CMD_FLUSH_BIT]))));

    // telegram position and command byte capture
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_pos_q <= '0;
            cmd_select_q <= '0;
        end else if (i_out_valid) begin
            if (i_out_first) begin
                out_pos_q <= `TG_CTRL1_IDX;
                cmd_select_q <= '0;
            end else begin
                if (out_pos_q == `TG_CTRL1_IDX) begin
                    cmd_select_q <= i_out_byte;
                end
                // saturate so a long telegram never wraps into the header
                if (out_pos_q != 8'hFF) begin
                    out_pos_q <= out_pos_q + 8'h01;
                end
            end
        end
    end

    byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_clear(1'b0),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_out_byte),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    assign fifo_out_ready = (ser_q == SER_DATA) && (!o_ser_valid || i_ser_ready);

    // serial framer: start char, payload, CR LF
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ser_q <= SER_IDLE;
            o_ser_valid <= 1'b0;
            ser_byte_q <= '0;
            lf_q <= 1'b0;
            ser_have_data_q <= 1'b0;
        end else if (!o_ser_valid || i_ser_ready) begin
            o_ser_valid <= 1'b0;
            unique case (ser_q)
                SER_IDLE: begin
                    if (fifo_out_valid) begin
                        ser_byte_q <= `SER_START_CHAR;
                        o_ser_valid <= 1'b1;
                        ser_q <= SER_DATA;
                        ser_have_data_q <= 1'b0;
                    end
                end
                SER_START: begin
                    ser_q <= SER_DATA;
                end
                SER_DATA: begin
                    if (fifo_out_valid) begin
                        ser_byte_q <= fifo_out_data;
                        o_ser_valid <= 1'b1;
                        ser_have_data_q <= 1'b1;
                    end else if (ser_have_data_q) begin
                        // fifo drained: close the frame
                        ser_byte_q <= `SER_CR_CHAR;
                        o_ser_valid <= 1'b1;
                        lf_q <= 1'b1;
                        ser_q <= SER_CR_LF;
                    end
                end
                SER_CR_LF: begin
                    if (lf_q) begin
                        ser_byte_q <= `SER_LF_CHAR;
                        o_ser_valid <= 1'b1;
                        lf_q <= 1'b0;
                    end else begin
                        ser_q <= SER_IDLE;
                    end
                end
            endcase
        end
    end
    assign o_ser_byte = ser_byte_q;

    // write acknowledge toggles per completed append or flush
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            write_ack_q <= 1'b0;
        end else if (cmd_done) begin
            write_ack_q <= ~write_ack_q;
        end
    end

    // service mode follows the selector
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            service_mode_flag_q <= 1'b0;
        end else begin
            service_mode_flag_q <= (i_svc_sel == SVC_GATEWAY) ||
                (i_svc_sel == SVC_PERIPH);
        end
    end

    // pending data only meaningful in collective mode
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pending_data_flag_q <= 1'b0;
        end else begin
            pending_data_flag_q <= !i_transparent && (i_tx_buf_level != 11'h000);
        end
    end

    // overflow flag tracks the 1 kbyte buffer and a full fifo; clears itself on space
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            buffer_overflow_flag_q <= 1'b0;
        end else begin
            buffer_overflow_flag_q <= (i_buf_level >= 11'(`TX_BUF_BYTES)) ||
                !fifo_in_ready;
        end
    end
    // request-to-send off while overflowed
    assign o_rts = !buffer_overflow_flag_q;

    // received data assembly into the input data bytes
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_cnt_q <= '0;
            rx_trunc_q <= 1'b0;
        end else if (i_rx_end) begin
            rx_cnt_q <= '0;
            rx_trunc_q <= 1'b0;
        end else if (i_rx_valid) begin
            if (rx_cnt_q < i_data_len_cfg) begin
                rx_cnt_q <= rx_cnt_q + 8'h01;
            end else begin
                rx_trunc_q <= 1'b1;
            end
        end
    end

    // input data byte storage, one slot per position
    for (genvar g = 0; g < 256; g++) begin : g_in
        always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
            if (!i_arst_n) begin
                in_data_q[g] <= '0;
            end else if (i_rx_valid && !i_rx_end && rx_cnt_q == 8'(g) &&
                rx_cnt_q < i_data_len_cfg) begin
                in_data_q[g] <= i_rx_byte;
            end
        end
    end

    // length code and block/new-data toggles on each completed set
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            payload_length_code_q <= `LEN_RESET;
            block_ready_toggle_q <= 1'b0;
            new_data_toggle_q <= 1'b0;
        end else if (i_rx_end) begin
            payload_length_code_q <= rx_cnt_q;
            if (i_transparent) begin
                new_data_toggle_q <= ~new_data_toggle_q;
            end else begin
                block_ready_toggle_q <= ~block_ready_toggle_q;
            end
        end
    end

    // data loss: sticky; a new loss in the reset cycle wins
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_loss_flag_q <= 1'b0;
        end else if (i_rx_lost || drop_byte || (i_rx_valid && !i_rx_end &&
            rx_cnt_q >= i_data_len_cfg) || (i_rx_end && rx_trunc_q)) begin
            data_loss_flag_q <= 1'b1;
        end else if (i_reset_cmd) begin
            data_loss_flag_q <= 1'b0;
        end
    end

    // status byte zero assembly, bit one reads zero
    always_comb begin
        o_status_flags_byte = `STS_RESET;
        o_status_flags_byte[`STS_WACK_BIT] = write_ack_q;
        o_status_flags_byte[`STS_SERVICE_BIT] = service_mode_flag_q;
        o_status_flags_byte[`STS_PEND_BIT] = pending_data_flag_q;
        o_status_flags_byte[`STS_BLOCK_BIT] = block_ready_toggle_q;
        o_status_flags_byte[`STS_LOSS_BIT] = data_loss_flag_q;
        o_status_flags_byte[`STS_OVERFLOW_BIT] = buffer_overflow_flag_q;
        o_status_flags_byte[`STS_NEWDATA_BIT] = new_data_toggle_q;
    end
    assign o_payload_length_byte = payload_length_code_q;

    // input telegram byte fetch: status, length, then data
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            in_byte_q <= '0;
        end else if (i_in_rd) begin
            if (i_in_index == `TG_CTRL0_IDX) begin
                in_byte_q <= o_status_flags_byte;
            end else if (i_in_index == `TG_CTRL1_IDX) begin
                in_byte_q <= payload_length_code_q;
            end else begin
                in_byte_q <= in_data_q[8'(i_in_index - `TG_DATA_IDX)];
            end
        end
    end
    assign o_in_byte = in_byte_q;
endmodule : telegram_status_framer
`default_nettype wire

// [telegram_status_framer_assertions.sv]
// concurrent checks on the telegram framer ports
`include "telegram_params.svh"
`default_nettype none
module telegram_status_framer_assertions (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_out_valid,
    input wire logic i_rx_end,
    input wire logic i_transparent,
    input wire logic [1:0] i_svc_sel,
    input wire logic i_reset_cmd,
    input wire logic [10:0] i_tx_buf_level,
    input wire logic [10:0] i_buf_level,
    input wire logic i_in_rd,
    input wire logic [7:0] i_in_index,
    input wire logic [7:0] o_in_byte,
    input wire logic o_ser_valid,
    input wire logic [7:0] o_ser_byte,
    input wire logic i_ser_ready,
    input wire logic o_rts,
    input wire logic [7:0] o_status_flags_byte
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // short alias for the flag byte
    wire logic [7:0] sts = o_status_flags_byte;
    a_rts_follows_ovf: assert property (o_rts == !sts[`STS_OVERFLOW_BIT])
        else $error("rts does not mirror overflow flag");
    a_ovf_on_full: assert property (i_buf_level >= 11'(`TX_BUF_BYTES) |=>
        sts[`STS_OVERFLOW_BIT] && !o_rts)
        else $error("overflow flag not raised");
    a_unused_bit_zero: assert property (sts[1] == 1'b0)
        else $error("unused status bit set");
    a_svc_flag_set: assert property ((i_svc_sel != 2'h0) |=> sts[`STS_SERVICE_BIT])
        else $error("service flag not set");
    a_svc_flag_clear: assert property ((i_svc_sel == 2'h0) |=> !sts[`STS_SERVICE_BIT])
        else $error("service flag not cleared");
    a_pend_tracks_level: assert property (!i_transparent |=>
        sts[`STS_PEND_BIT] == $past(i_tx_buf_level != 11'h000))
        else $error("pending flag wrong");
    a_loss_stays_set: assert property (sts[`STS_LOSS_BIT] && !i_reset_cmd |=>
        sts[`STS_LOSS_BIT])
        else $error("data loss flag dropped");
    a_ready_toggle_cause: assert property ($changed(sts[`STS_BLOCK_BIT]) |->
        $past(i_rx_end) && !$past(i_transparent))
        else $error("block ready toggled without set end");
    a_new_data_cause: assert property ($changed(sts[`STS_NEWDATA_BIT]) |->
        $past(i_rx_end) && $past(i_transparent))
        else $error("new data toggled without set end");
    a_wack_cause: assert property ($changed(sts[`STS_WACK_BIT]) |->
        $past(i_out_valid) || $past(i_out_valid, 2))
        else $error("write ack toggled without telegram");
    a_ser_byte_holds: assert property (o_ser_valid && !i_ser_ready |=>
        o_ser_valid && $stable(o_ser_byte))
        else $error("serial byte not held");
    a_fetch_status: assert property (i_in_rd && i_in_index == 8'h00 |=>
        o_in_byte == $past(sts))
        else $error("fetched status differs");
endmodule : telegram_status_framer_assertions
bind telegram_status_framer telegram_status_framer_assertions u_chk (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_out_valid(i_out_valid),
    .i_rx_end(i_rx_end), .i_transparent(i_transparent), .i_svc_sel(i_svc_sel),
    .i_reset_cmd(i_reset_cmd), .i_tx_buf_level(i_tx_buf_level), .i_in_rd(i_in_rd),
    .i_buf_level(i_buf_level),
    .i_in_index(i_in_index), .o_in_byte(o_in_byte), .o_ser_valid(o_ser_valid),
    .o_ser_byte(o_ser_byte), .i_ser_ready(i_ser_ready), .o_rts(o_rts),
    .o_status_flags_byte(o_status_flags_byte));
`default_nettype wire

// [plc_model.sv]
// controller model: writes telegrams, fetches input bytes
`default_nettype none
module plc_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_in_byte,
    output logic o_out_valid,
    output logic [7:0] o_out_byte,
    output logic o_out_first,
    output logic o_out_last,
    output logic o_in_rd,
    output logic [7:0] o_in_index
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] seen_q = 8'h00; // status last seen, for toggle events
    initial begin
        {o_out_valid, o_out_first, o_out_last, o_in_rd} = 4'h0;
        o_out_byte = 8'h00;
        o_in_index = 8'h00;
    end
    // control bytes first, payload from byte two, back to back
    task automatic send(input logic [7:0] cmd, input int n, input logic [7:0] base);
        for (int i = 0; i < n + 2; i++) begin
            @(posedge i_clk_sys);
            #1;
            o_out_valid = 1'b1;
            o_out_first = (i == 0);
            o_out_last = (i == n + 1);
            o_out_byte = (i == 0) ? 8'h00 : (i == 1) ? cmd : base + 8'(i - 2);
        end
        @(posedge i_clk_sys);
        #1;
        o_out_valid = 1'b0;
        o_out_last = 1'b0;
        o_out_byte = ~o_out_byte; // released bus shows no stale byte
    endtask : send
    // fetch one input byte; answer is registered, so read a cycle later
    task automatic fetch(input logic [7:0] idx, output logic [7:0] val);
        @(posedge i_clk_sys);
        #1;
        o_in_rd = 1'b1;
        o_in_index = idx;
        @(posedge i_clk_sys);
        #1;
        o_in_rd = 1'b0;
        val = i_in_byte;
    endtask : fetch
    // any change of a toggle bit since last look counts as one event
    task automatic events(input logic [7:0] mask, output logic [7:0] hit);
        logic [7:0] cur;
        fetch(8'h00, cur);
        hit = (cur ^ seen_q) & mask;
        seen_q = cur;
    endtask : events
endmodule : plc_model
`default_nettype wire

// [telegram_status_framer_tb_top.sv]
// self-checking bench for the telegram framer
`default_nettype none
module telegram_status_framer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, arst_n = 1'b0, rx_valid = 1'b0, rx_end = 1'b0, rx_lost = 1'b0;
    logic transparent = 1'b0, reset_cmd = 1'b0, ser_ready = 1'b0;
    logic [7:0] rx_byte = 8'h00, len_cfg = 8'h08, h, b;
    logic [1:0] svc = 2'h0;
    logic [10:0] tx_lvl = 11'h000, buf_lvl = 11'h000;
    wire logic ov, of, ol, rd, ser_valid, rts;
    wire logic [7:0] ob, idx, in_byte, ser_byte, sts, len;
    int err_total = 0, cmp_count = 0;
    initial forever #5 clk = ~clk;
    plc_model u_plc (.i_clk_sys(clk), .i_in_byte(in_byte), .o_out_valid(ov),
        .o_out_byte(ob), .o_out_first(of), .o_out_last(ol), .o_in_rd(rd), .o_in_index(idx));
    telegram_status_framer DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_out_valid(ov),
        .i_out_byte(ob), .i_out_first(of), .i_out_last(ol), .i_in_rd(rd), .i_in_index(idx),
        .o_in_byte(in_byte), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_end(rx_end),
        .i_rx_lost(rx_lost), .i_data_len_cfg(len_cfg), .i_transparent(transparent),
        .i_svc_sel(svc), .i_reset_cmd(reset_cmd), .i_tx_buf_level(tx_lvl),
        .i_buf_level(buf_lvl), .o_ser_valid(ser_valid), .o_ser_byte(ser_byte),
        .i_ser_ready(ser_ready), .o_rts(rts), .o_status_flags_byte(sts),
        .o_payload_length_byte(len));
    // byte compare, used for flags, counts and serial bytes alike
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // take one serial byte after a two-cycle stall
    task automatic ser_get(output logic [7:0] v);
        for (int n = 0; n < 50 && ser_valid !== 1'b1; n++) tick(1);
        tick(2);
        ser_ready = 1'b1;
        v = ser_byte;
        tick(1);
        ser_ready = 1'b0;
    endtask : ser_get
    // expect start char, one payload byte, CR LF
    task automatic frame(input logic [7:0] d);
        logic [7:0] exp [4];
        exp = '{8'h02, d, 8'h0D, 8'h0A};
        foreach (exp[i]) begin
            ser_get(b);
            chk(b, exp[i]);
        end
    endtask : frame
    task automatic t_reset();
        chk(sts, 8'h00);
        chk(len, 8'h00);
        chk({7'h00, rts}, 8'h01);
        $display("reset test done");
    endtask : t_reset
    task automatic t_write();
        u_plc.send(8'h08, 1, 8'hA5);
        u_plc.events(8'h01, h);
        chk(h, 8'h01);
        frame(8'hA5);
        u_plc.send(8'h04, 0, 8'h00);
        u_plc.events(8'h01, h);
        chk(h, 8'h01);
        $display("write test done");
    endtask : t_write
    task automatic t_flags();
        for (int i = 1; i <= 3; i++) begin
            svc = 2'(i % 3);
            tick(2);
            chk({7'h00, sts[2]}, {7'h00, i != 3});
        end
        tx_lvl = 11'h005;
        tick(2);
        chk({7'h00, sts[3]}, 8'h01);
        tx_lvl = 11'h000;
        buf_lvl = 11'h400;
        tick(2);
        chk({5'h00, sts[6], sts[3], rts}, 8'h04);
        buf_lvl = 11'h000;
        tick(2);
        chk({6'h00, sts[6], rts}, 8'h01);
        $display("flag test done");
    endtask : t_flags
    task automatic t_loss();
        len_cfg = 8'h01;
        u_plc.send(8'h08, 2, 8'h10);
        frame(8'h10);
        chk({7'h00, sts[5]}, 8'h01);
        reset_cmd = 1'b1;
        tick(1);
        reset_cmd = 1'b0;
        tick(1);
        chk({7'h00, sts[5]}, 8'h00);
        rx_lost = 1'b1;
        tick(1);
        rx_lost = 1'b0;
        tick(5);
        chk({7'h00, sts[5]}, 8'h01);
        reset_cmd = 1'b1;
        tick(1);
        reset_cmd = 1'b0;
        rx_set(3);
        chk({7'h00, sts[5]}, 8'h01);
        chk(len, 8'h01);
        len_cfg = 8'h08;
        $display("loss test done");
    endtask : t_loss
    // one received set of n bytes, then its end marker
    task automatic rx_set(input int n);
        for (int i = 0; i < n; i++) begin
            rx_valid = 1'b1;
            rx_byte = 8'(8'h30 + i);
            tick(1);
        end
        rx_valid = 1'b0;
        rx_byte = 8'hFF;
        rx_end = 1'b1;
        tick(1);
        rx_end = 1'b0;
        tick(2);
    endtask : rx_set
    task automatic t_rx();
        u_plc.events(8'h90, h);
        rx_set(3);
        u_plc.events(8'h90, h);
        chk(h, 8'h10);
        chk(len, 8'h03);
        u_plc.fetch(8'h02, b);
        chk(b, 8'h30);
        transparent = 1'b1;
        rx_set(2);
        u_plc.events(8'h90, h);
        chk(h, 8'h80);
        transparent = 1'b0;
        $display("receive test done");
    endtask : t_rx
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // watchdog at 20000 cycles, well beyond the roughly one hundred cycles the tests need
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        tick(4);
        arst_n = 1'b1;
        t_reset();
        t_write();
        t_flags();
        t_loss();
        t_rx();
        conclude();
    end
endmodule : telegram_status_framer_tb_top
`default_nettype wire
